// ### pll_synth_consts.vh
`ifndef PLL_SYNTH_CONSTS_VH
`define PLL_SYNTH_CONSTS_VH

// word length and bit positions; shift-register index = printed bit - 1
`define WORD_BITS          24
`define REGISTER_SELECT    0
`define SECONDARY_ADDRESS  23
// channel word
`define SWALLOW_LSB        1
`define SWALLOW_MSB        7
`define MAIN_RATIO_LSB     8
`define MAIN_RATIO_MSB     18
`define CHANNEL_ENABLE     21
`define BAND_SELECT        22
// setup word
`define REF_RATIO_LSB      1
`define REF_RATIO_MSB      11
`define RELOAD_MODE        12
`define BAND2_SET_LSB      14
`define BAND2_SET_MSB      15
`define BAND1_SET_LSB      17
`define BAND1_SET_MSB      18
`define SOURCE_SELECT      20
`define SETUP_ENABLE       21
`define LOCK_OUT_ENABLE    22
// reset values
`define WORD_RESET         24'h000000
`define SEL_CHANNEL        1'b0

`endif

// ### serial_word_rx.v
`timescale 1ns/1ps
`include "pll_synth_consts.vh"

module serial_word_rx (
    input  wire        clk,
    input  wire        nrst,
    input  wire        ser_clk,
    input  wire        ser_data,
    input  wire        ser_latch,
    output reg  [23:0] word_r,
    output reg         word_stb_r
);

reg  [2:0]  clk_s_r;
reg  [2:0]  lat_s_r;
reg  [1:0]  dat_s_r;
reg  [23:0] shift_r;
reg  [4:0]  count_r;

wire clk_rise = clk_s_r[1] & ~clk_s_r[2];
wire lat_rise = lat_s_r[1] & ~lat_s_r[2];

////////////////////////////////////////////////////////////////////////
always @(posedge clk) begin
    if (!nrst) begin
        clk_s_r    <= 3'h0;
        lat_s_r    <= 3'h0;
        dat_s_r    <= 2'h0;
        shift_r    <= 24'h000000;
        count_r    <= 5'h00;
        word_r     <= 24'h000000;
        word_stb_r <= 1'b0;
    end else begin
        clk_s_r    <= {clk_s_r[1:0], ser_clk};
        lat_s_r    <= {lat_s_r[1:0], ser_latch};
        dat_s_r    <= {dat_s_r[0], ser_data};
        word_stb_r <= 1'b0;
        if (lat_rise) begin
            count_r <= 5'h00;
            // only a full word, with the sharing bit low, is taken
            if (count_r == `WORD_BITS && !shift_r[`SECONDARY_ADDRESS]) begin
                word_r     <= shift_r;
                word_stb_r <= 1'b1;
            end
        end else if (clk_rise) begin
            // first bit sent ends up in the top position
            shift_r <= {shift_r[22:0], dat_s_r[1]};
            if (count_r != 5'h1F)
                count_r <= count_r + 5'h01;
        end
    end
end

endmodule // serial_word_rx

// ### pll_synth_program_words.v
`timescale 1ns/1ps
`include "pll_synth_consts.vh"

module pll_synth_program_words (
    input  wire       REF_CLK,
    input  wire       NRST,
    input  wire       SER_CLK,
    input  wire       SER_DATA,
    input  wire       SER_LATCH,
    input  wire       POWERDOWN_PIN_N,
    input  wire       LOCK_STATUS,
    input  wire       PRESCALER_IN,
    input  wire       REF_IN,
    output reg        LOCK_INDICATOR_PIN,
    output reg        CURRENT_SOURCE_SELECT,
    output reg  [1:0] CURRENT_SETTING,
    output reg        BAND_SELECT,
    output reg        RUN,
    output reg        MAIN_DIV_OUT,
    output reg        REF_DIV_OUT,
    output reg        MODULUS_CTRL
);

wire [23:0] word;
wire        word_stb;

reg  [23:0] setup_word_r;
reg  [23:0] channel_word_r;
reg         last_sel_r;
reg  [1:0]  pd_s_r;
reg  [1:0]  lock_s_r;
reg  [2:0]  rf_s_r;
reg  [2:0]  ref_s_r;
reg  [10:0] main_cnt_r;
reg  [6:0]  swallow_cnt_r;
reg  [10:0] ref_cnt_r;
reg         forced_r;

reg         enable_nxt;
reg         band_nxt;

wire [6:0]  swallow_val = channel_word_r[`SWALLOW_MSB:`SWALLOW_LSB];
wire [10:0] main_val = channel_word_r[`MAIN_RATIO_MSB:`MAIN_RATIO_LSB];
wire [10:0] ref_val  = setup_word_r[`REF_RATIO_MSB:`REF_RATIO_LSB];
wire        forced   = setup_word_r[`RELOAD_MODE];
wire        rf_edge  = rf_s_r[1] & ~rf_s_r[2];
wire        ref_edge = ref_s_r[1] & ~ref_s_r[2];

serial_word_rx u_rx (
    .clk        (REF_CLK),
    .nrst       (NRST),
    .ser_clk    (SER_CLK),
    .ser_data   (SER_DATA),
    .ser_latch  (SER_LATCH),
    .word_r     (word),
    .word_stb_r (word_stb)
);

////////////////////////////////////////////////////////////////////////
// programming words; powerdown never touches them
always @(posedge REF_CLK) begin
    if (!NRST) begin
        setup_word_r   <= `WORD_RESET;
        channel_word_r <= `WORD_RESET;
        last_sel_r     <= `SEL_CHANNEL;
        forced_r       <= 1'b0;
    end else begin
        forced_r <= 1'b0;
        if (word_stb) begin
            last_sel_r <= word[`REGISTER_SELECT];
            forced_r   <= 1'b1;
            if (word[`REGISTER_SELECT])
                setup_word_r <= word;
            else
                channel_word_r <= word;
        end
    end
end

////////////////////////////////////////////////////////////////////////
always @* begin
    if (last_sel_r)
        enable_nxt = setup_word_r[`SETUP_ENABLE];
    else
        enable_nxt = channel_word_r[`CHANNEL_ENABLE];
    enable_nxt = enable_nxt & pd_s_r[1];
    band_nxt = channel_word_r[`BAND_SELECT];
end

always @(posedge REF_CLK) begin
    if (!NRST) begin
        pd_s_r                <= 2'h0;
        lock_s_r              <= 2'h0;
        RUN                   <= 1'b0;
        LOCK_INDICATOR_PIN    <= 1'b1;
        CURRENT_SOURCE_SELECT <= 1'b0;
        CURRENT_SETTING       <= 2'h0;
        BAND_SELECT           <= 1'b0;
    end else begin
        pd_s_r                <= {pd_s_r[0], POWERDOWN_PIN_N};
        lock_s_r              <= {lock_s_r[0], LOCK_STATUS};
        RUN                   <= enable_nxt;
        LOCK_INDICATOR_PIN    <= ~setup_word_r[`LOCK_OUT_ENABLE]
                                 | lock_s_r[1];
        CURRENT_SOURCE_SELECT <= setup_word_r[`SOURCE_SELECT];
        BAND_SELECT           <= band_nxt;
        if (band_nxt)
            CURRENT_SETTING <=
                setup_word_r[`BAND2_SET_MSB:`BAND2_SET_LSB];
        else
            CURRENT_SETTING <=
                setup_word_r[`BAND1_SET_MSB:`BAND1_SET_LSB];
    end
end

////////////////////////////////////////////////////////////////////////
// dividers; ratios below 2 are not guarded, host must avoid them
always @(posedge REF_CLK) begin
    if (!NRST) begin
        rf_s_r        <= 3'h0;
        ref_s_r       <= 3'h0;
        main_cnt_r    <= 11'h000;
        swallow_cnt_r <= 7'h00;
        ref_cnt_r     <= 11'h000;
        MAIN_DIV_OUT  <= 1'b0;
        REF_DIV_OUT   <= 1'b0;
        MODULUS_CTRL  <= 1'b0;
    end else begin
        rf_s_r       <= {rf_s_r[1:0], PRESCALER_IN};
        ref_s_r      <= {ref_s_r[1:0], REF_IN};
        MAIN_DIV_OUT <= 1'b0;
        REF_DIV_OUT  <= 1'b0;
        MODULUS_CTRL <= (swallow_cnt_r != 7'h00) & RUN;
        if (!RUN) begin
            // reloaded from the word, not cleared, so a wake-up restarts from the word
            main_cnt_r    <= main_val;
            swallow_cnt_r <= swallow_val;
            ref_cnt_r     <= ref_val;
        end else if (forced_r && forced) begin
            main_cnt_r    <= main_val;
            swallow_cnt_r <= swallow_val;
            ref_cnt_r     <= ref_val;
        end else begin
            if (rf_edge) begin
                if (main_cnt_r <= 11'h001) begin
                    main_cnt_r    <= main_val;
                    swallow_cnt_r <= swallow_val;
                    MAIN_DIV_OUT  <= 1'b1;
                end else begin
                    main_cnt_r <= main_cnt_r - 11'h001;
                    if (swallow_cnt_r != 7'h00)
                        swallow_cnt_r <= swallow_cnt_r - 7'h01;
                end
            end
            if (ref_edge) begin
                if (ref_cnt_r <= 11'h001) begin
                    ref_cnt_r   <= ref_val;
                    REF_DIV_OUT <= 1'b1;
                end else begin
                    ref_cnt_r <= ref_cnt_r - 11'h001;
                end
            end
        end
    end
end

endmodule // pll_synth_program_words

// ### pll_synth_checker_asserts.sv
`timescale 1ns/1ps
module pll_synth_checker (
    input wire       REF_CLK,
    input wire       NRST,
    input wire       SER_LATCH,
    input wire       POWERDOWN_PIN_N,
    input wire       LOCK_STATUS,
    input wire       LOCK_INDICATOR_PIN,
    input wire       CURRENT_SOURCE_SELECT,
    input wire [1:0] CURRENT_SETTING,
    input wire       BAND_SELECT,
    input wire       RUN,
    input wire       MAIN_DIV_OUT,
    input wire       REF_DIV_OUT,
    input wire       MODULUS_CTRL
);
    reg [3:0] lat_age_r;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    // cycles since latch pin high; word outputs may move only soon after
    always @(posedge REF_CLK) begin
        if (!NRST || SER_LATCH)
            lat_age_r <= 4'h0;
        else
            lat_age_r <= lat_age_r + {3'h0, lat_age_r != 4'hF};
    end
    a_reset_state: assert property (disable iff (1'b0)
        !NRST |=> !RUN && LOCK_INDICATOR_PIN) else $error("reset state");
    a_pin_run: assert property (!POWERDOWN_PIN_N [*5] |-> !RUN)
        else $error("run with pin low");
    a_lock_high: assert property (LOCK_STATUS [*5] |-> LOCK_INDICATOR_PIN)
        else $error("lock pin low while locked");
    a_mod_idle: assert property (!RUN [*2] |-> !MODULUS_CTRL)
        else $error("modulus control in powerdown");
    a_main_pulse: assert property (MAIN_DIV_OUT |=> !MAIN_DIV_OUT)
        else $error("main pulse too long");
    a_ref_pulse: assert property (REF_DIV_OUT |=> !REF_DIV_OUT)
        else $error("ref pulse too long");
    a_div_idle: assert property (!RUN [*2] |-> !(MAIN_DIV_OUT || REF_DIV_OUT))
        else $error("divider pulse in powerdown");
    a_words_held: assert property ($changed({CURRENT_SOURCE_SELECT,
        BAND_SELECT, CURRENT_SETTING}) |-> lat_age_r < 4'hA)
        else $error("word output moved without latch");
endmodule // pll_synth_checker
bind pll_synth_program_words pll_synth_checker pll_synth_checker_inst (
    .REF_CLK(REF_CLK), .NRST(NRST), .SER_LATCH(SER_LATCH),
    .POWERDOWN_PIN_N(POWERDOWN_PIN_N), .LOCK_STATUS(LOCK_STATUS),
    .LOCK_INDICATOR_PIN(LOCK_INDICATOR_PIN), .RUN(RUN),
    .CURRENT_SOURCE_SELECT(CURRENT_SOURCE_SELECT), .BAND_SELECT(BAND_SELECT),
    .CURRENT_SETTING(CURRENT_SETTING), .MAIN_DIV_OUT(MAIN_DIV_OUT),
    .REF_DIV_OUT(REF_DIV_OUT), .MODULUS_CTRL(MODULUS_CTRL));

// ### host_model.sv
`timescale 1ns/1ps
module host_model (
    output reg SER_CLK,
    output reg SER_DATA,
    output reg SER_LATCH
);
    initial begin
        SER_CLK = 1'b0;
        SER_DATA = 1'b0;
        SER_LATCH = 1'b0;
    end
    // first bit out is the highest; bit clock idles low between frames
    task send(input [23:0] w, input integer n);
        integer i;
        begin
            for (i = n - 1; i >= 0; i--) begin
                SER_DATA = w[i];
                #160 SER_CLK = 1'b1;
                #160 SER_CLK = 1'b0;
            end
            // data no longer held: show the inverse, not the last bit
            SER_DATA = ~SER_DATA;
            #160 SER_LATCH = 1'b1;
            #160 SER_LATCH = 1'b0;
            #400;
        end
    endtask
endmodule // host_model

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
    reg        REF_CLK, NRST, POWERDOWN_PIN_N, LOCK_STATUS;
    reg        PRESCALER_IN, REF_IN, src;
    reg [23:0] w, s, c;
    wire       SER_CLK, SER_DATA, SER_LATCH, LOCK_INDICATOR_PIN, RUN;
    wire       CURRENT_SOURCE_SELECT, BAND_SELECT, MAIN_DIV_OUT;
    wire       REF_DIV_OUT, MODULUS_CTRL;
    wire [1:0] CURRENT_SETTING;
    integer    miscompares, checked, seed, i, n, g;
    host_model host_model_inst (.SER_CLK(SER_CLK), .SER_DATA(SER_DATA),
        .SER_LATCH(SER_LATCH));
    pll_synth_program_words pll_synth_program_words_inst (
        .REF_CLK(REF_CLK), .NRST(NRST), .SER_CLK(SER_CLK),
        .SER_DATA(SER_DATA), .SER_LATCH(SER_LATCH),
        .POWERDOWN_PIN_N(POWERDOWN_PIN_N), .LOCK_STATUS(LOCK_STATUS),
        .PRESCALER_IN(PRESCALER_IN), .REF_IN(REF_IN),
        .LOCK_INDICATOR_PIN(LOCK_INDICATOR_PIN),
        .CURRENT_SOURCE_SELECT(CURRENT_SOURCE_SELECT),
        .CURRENT_SETTING(CURRENT_SETTING), .BAND_SELECT(BAND_SELECT),
        .RUN(RUN), .MAIN_DIV_OUT(MAIN_DIV_OUT), .REF_DIV_OUT(REF_DIV_OUT),
        .MODULUS_CTRL(MODULUS_CTRL));
    initial begin
        REF_CLK = 1'b0;
        forever #20 REF_CLK = ~REF_CLK;
    end
    // rising edges every 8 cycles, well apart from the sampling edge
    always #160 PRESCALER_IN = ~PRESCALER_IN;
    always #160 REF_IN = ~REF_IN;
    task chk(input string nm, input [23:0] got, input [23:0] exp);
        begin
            checked++;
            if (got !== exp) begin
                miscompares++;
                $display("mismatch %s expected %0h seen %0h", nm, exp, got);
            end
        end
    endtask
    task finish_test;
        begin
            $display("checked %0d miscompares %0d", checked, miscompares);
            if (miscompares == 0 && checked > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    // cycles between two successive pulses of one divider output
    task gap(input sel, output integer g);
        integer k, p;
        begin
            g = 0;
            p = 0;
            for (k = 0; k < 30000 && p < 2; k++) begin
                @(posedge REF_CLK);
                #1;
                if (p > 0) g++;
                if ((sel ? REF_DIV_OUT : MAIN_DIV_OUT) === 1'b1) p++;
            end
            if (p < 2) begin
                miscompares++;
                finish_test;
            end
        end
    endtask
    initial begin
        {NRST, POWERDOWN_PIN_N, LOCK_STATUS, PRESCALER_IN, REF_IN} = 5'h00;
        {miscompares, checked, seed, src, s, c} = {32'h0, 32'h0, 32'd78, 49'h0};
        repeat (5) @(posedge REF_CLK);
        #1 NRST = 1'b1;
        for (i = 0; i < 40; i++) begin
            w = $random(seed);
            w[23] = ($random(seed) % 4 == 0);
            n = ($random(seed) % 6 == 0) ? 23 : 24;
            @(posedge REF_CLK);
            #1;
            POWERDOWN_PIN_N = $random(seed);
            LOCK_STATUS = $random(seed);
            host_model_inst.send(w, n);
            if (n == 24 && !w[23]) begin
                if (w[0]) s = w; else c = w;
                src = w[0];
            end
            chk("run", RUN, POWERDOWN_PIN_N & (src ? s[21] : c[21]));
            chk("source", CURRENT_SOURCE_SELECT, s[20]);
            chk("band", BAND_SELECT, c[22]);
            chk("setting", CURRENT_SETTING, c[22] ? s[15:14] : s[18:17]);
            chk("lock", LOCK_INDICATOR_PIN, !(s[22] & !LOCK_STATUS));
        end
        $display("test words done");
        POWERDOWN_PIN_N = 1'b1;
        host_model_inst.send(24'h201007, 24);
        host_model_inst.send(24'h200504, 24);
        gap(1'b0, g);
        chk("main gap", g, 5 * 8);
        // swallow count 2 holds modulus control for 2 input periods per wrap
        n = 0;
        repeat (40) begin
            @(posedge REF_CLK);
            #1;
            if (MODULUS_CTRL === 1'b1) n++;
        end
        chk("modulus", n, 2 * 8);
        gap(1'b1, g);
        chk("ref gap", g, 3 * 8);
        $display("test divide done");
        finish_test;
    end
endmodule // testbench
